// ### snm_spi_mem.sv
/*
 * spi target with a 32k x 8 array, status byte, sleep and identifier.
 * assumes pins arrive asynchronously and the serial clock is far slower
 * than clk_sys_i (80 ns period in the bench).
 */
// Contract
// - serial link works in spi mode 0 and mode 3.
// - chip select high keeps output off and ignores other pins.
// - input sampled on clock rise, output changes on clock fall.
// - pause pin low while selected freezes transfer, output off.
// - bit 7 protect enable, written and read by status commands.
// - bits 6 to 4 stored and read back; bit 0 reads zero.
// - bits 3 and 2 pick the protected region, read and writable.
// - opcode 06 sets the write latch, 04 clears it.
// - latch clears at reset, disable, write end, wake.
// - status and memory writes do nothing while latch is clear.
// - eight-bit opcode msb first; early deselect runs nothing.
// - status read repeats status byte while clocks continue.
// - status write takes one byte, ignoring bits 1 and 0.
// - memory read after 16-bit address outputs addressed byte.
// - further read bytes come from incrementing, wrapping address.
// - memory write stores each byte once eight bits arrive.
// - further write bytes go to incrementing, wrapping address.
// - identifier read shifts 32 bits then holds the last.
// - sleep opcode sleeps at deselect unless a clock intervenes.
// - asleep, clock and input ignored and output off.
// - wake 400 us after select falls; host waits that long.
// - region bits protect none, upper quarter, upper half, all.
// - status write refused when protect enable and guard low.
// - deselect while paused aborts; latch kept for every opcode.
`default_nettype none

module snm_spi_mem
	import snm_pkg::*;
#(
	parameter int unsigned WAKE_CYCLES_P = WAKE_CYCLES
) (
	input  wire logic clk_sys_i,
	input  wire logic rst_n_i,
	input  wire logic cs_n_i,
	input  wire logic sck_i,
	input  wire logic si_i,
	input  wire logic hold_n_i,
	input  wire logic write_guard_n_i,
	output var  logic so_o,
	output var  logic so_oe_o
);

	localparam logic [15:0] WAKE_LAST = 16'(WAKE_CYCLES_P - 1);

	// pin synchronisers
	snm_pins_type pins_in;
	snm_pins_type s1_reg;
	snm_pins_type s2_reg;
	snm_pins_type s3_reg;
	snm_pins_type filt_reg;
	snm_pins_type filt_next;

	assign pins_in = '{cs_n: cs_n_i, sck: sck_i, si: si_i,
		hold_n: hold_n_i, wp_n: write_guard_n_i};

	always_comb begin
		filt_next = snm_pins_type'((s2_reg & s3_reg)
			| (filt_reg & (s2_reg | s3_reg)));
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_reg   <= PINS_IDLE;
			s2_reg   <= PINS_IDLE;
			s3_reg   <= PINS_IDLE;
			filt_reg <= PINS_IDLE;
		end else begin
			s1_reg   <= pins_in;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			filt_reg <= filt_next;
		end
	end

	logic sck_rise;
	logic sck_fall;
	logic cs_rise;
	logic cs_fall;
	logic selected;
	logic held;

	assign sck_rise = filt_next.sck & ~filt_reg.sck;
	assign sck_fall = ~filt_next.sck & filt_reg.sck;
	assign cs_rise  = filt_next.cs_n & ~filt_reg.cs_n;
	assign cs_fall  = ~filt_next.cs_n & filt_reg.cs_n;
	assign selected = ~filt_reg.cs_n;
	assign held     = selected & ~filt_reg.hold_n;

	// write buffer
	snm_wr_req_type buf_mem [BUF_DEPTH];
	logic           buf_rd_reg;
	logic           buf_rd_next;
	logic [1:0]     buf_cnt_reg;
	logic [1:0]     buf_cnt_next;
	logic           buf_in_ready;
	logic           buf_out_valid;
	logic           buf_out_ready;
	logic           buf_push;
	logic           buf_pop;
	logic           buf_wr_ptr;
	logic           push_valid_reg;
	logic           push_valid_next;
	snm_wr_req_type push_data_reg;
	snm_wr_req_type push_data_next;
	logic           rd_fetch;

	assign buf_in_ready  = (buf_cnt_reg != 2'(BUF_DEPTH));
	assign buf_out_valid = (buf_cnt_reg != 2'h0);
	assign buf_out_ready = ~rd_fetch;
	assign buf_push      = push_valid_reg & buf_in_ready;
	assign buf_pop       = buf_out_valid & buf_out_ready;
	assign buf_wr_ptr    = buf_rd_reg ^ buf_cnt_reg[0];

	always_comb begin
		buf_rd_next  = buf_rd_reg ^ buf_pop;
		buf_cnt_next = buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			buf_rd_reg  <= 1'b0;
			buf_cnt_reg <= 2'h0;
		end else begin
			buf_rd_reg  <= buf_rd_next;
			buf_cnt_reg <= buf_cnt_next;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (buf_push) begin
			buf_mem[buf_wr_ptr] <= push_data_reg;
		end
	end

	// memory array
	logic [7:0]        mem [MEM_WORDS];
	logic [ADDR_W-1:0] fetch_addr;
	logic [7:0]        mem_q;

	always_ff @(posedge clk_sys_i) begin
		if (buf_pop) begin
			mem[buf_mem[buf_rd_reg].addr] <= buf_mem[buf_rd_reg].data;
		end
	end

	// protocol engine
	snm_state_type     state_reg;
	snm_state_type     state_next;
	logic [4:0]        cnt_reg;
	logic [4:0]        cnt_next;
	logic [15:0]       rx_reg;
	logic [15:0]       rx_next;
	logic [31:0]       tx_reg;
	logic [31:0]       tx_next;
	logic              so_reg;
	logic              so_next;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;
	logic              wel_reg;
	logic              wel_next;
	logic [5:0]        nv_reg;
	logic [5:0]        nv_next;
	logic              arm_reg;
	logic              arm_next;
	logic              wcmd_reg;
	logic              wcmd_next;
	logic [15:0]       wake_reg;
	logic [15:0]       wake_next;
	logic [7:0]        in_byte;
	logic              talking;

	assign in_byte    = {rx_reg[6:0], filt_reg.si};
	assign fetch_addr = (state_reg == ST_ADDR) ?
		ADDR_W'({rx_reg[13:0], filt_reg.si}) : addr_reg + 15'h1;
	assign mem_q      = mem[fetch_addr];
	assign talking    = (state_reg == ST_SRD) | (state_reg == ST_RDATA)
		| (state_reg == ST_ID);

	always_comb begin
		state_next      = state_reg;
		cnt_next        = cnt_reg;
		rx_next         = rx_reg;
		tx_next         = tx_reg;
		so_next         = so_reg;
		addr_next       = addr_reg;
		wel_next        = wel_reg;
		nv_next         = nv_reg;
		arm_next        = arm_reg;
		wcmd_next       = wcmd_reg;
		wake_next       = wake_reg;
		push_valid_next = push_valid_reg & ~buf_in_ready;
		push_data_next  = push_data_reg;
		rd_fetch        = 1'b0;
		if (state_reg == ST_SLEEP) begin
			if (cs_fall) begin
				state_next = ST_WAKE;
				wake_next  = 16'h0;
			end
		end else if (state_reg == ST_WAKE) begin
			wake_next = wake_reg + 16'h1;
			if (wake_reg == WAKE_LAST) begin
				state_next = ST_OPCODE;
				cnt_next   = 5'h0;
				wel_next   = 1'b0;
			end
		end else if (cs_rise) begin
			state_next = ST_OPCODE;
			cnt_next   = 5'h0;
			arm_next   = 1'b0;
			wcmd_next  = 1'b0;
			if (!held) begin
				if (wcmd_reg) begin
					wel_next = 1'b0;
				end
				if (arm_reg) begin
					state_next = ST_SLEEP;
				end
			end
		end else if (selected && !held && sck_rise) begin
			rx_next  = {rx_reg[14:0], filt_reg.si};
			cnt_next = cnt_reg + 5'h1;
			arm_next = 1'b0;
			unique case (state_reg)
				ST_OPCODE: begin
					if (cnt_reg == 5'h7) begin
						cnt_next   = 5'h0;
						state_next = ST_DONE;
						unique case (in_byte)
							OP_LATCH_SET: wel_next = 1'b1;
							OP_LATCH_CLR: wel_next = 1'b0;
							OP_STATUS_RD: begin
								state_next = ST_SRD;
								tx_next    = {status_byte(nv_reg, wel_reg), 24'h0};
							end
							OP_STATUS_WR: begin
								state_next = ST_SWR;
								wcmd_next  = 1'b1;
							end
							OP_MEM_RD: state_next = ST_ADDR;
							OP_MEM_WR: begin
								state_next = ST_ADDR;
								wcmd_next  = 1'b1;
							end
							OP_IDENT_RD: begin
								state_next = ST_ID;
								tx_next    = ID_WORD;
							end
							OP_SLEEP: arm_next = 1'b1;
							default: state_next = ST_DONE;
						endcase
					end
				end
				ST_ADDR: begin
					if (cnt_reg == 5'hf) begin
						cnt_next  = 5'h0;
						addr_next = fetch_addr;
						if (wcmd_reg) begin
							state_next = ST_WDATA;
						end else begin
							state_next = ST_RDATA;
							rd_fetch   = 1'b1;
							tx_next    = {mem_q, 24'h0};
						end
					end
				end
				ST_RDATA: begin
					if (cnt_reg == 5'h7) begin
						cnt_next  = 5'h0;
						addr_next = fetch_addr;
						rd_fetch  = 1'b1;
						tx_next   = {mem_q, 24'h0};
					end
				end
				ST_WDATA: begin
					if (cnt_reg == 5'h7) begin
						cnt_next  = 5'h0;
						addr_next = addr_reg + 15'h1;
						if (wel_reg && !region_locked(addr_reg,
							nv_reg[STAT_RHI_IDX:STAT_RLO_IDX])) begin
							push_valid_next = 1'b1;
							push_data_next  = '{addr: addr_reg, data: in_byte};
						end
					end
				end
				ST_SRD: begin
					if (cnt_reg == 5'h7) begin
						cnt_next = 5'h0;
						tx_next  = {status_byte(nv_reg, wel_reg), 24'h0};
					end
				end
				ST_SWR: begin
					if (cnt_reg == 5'h7) begin
						state_next = ST_DONE;
						if (wel_reg && !(nv_reg[STAT_PEN_IDX]
							&& !filt_reg.wp_n)) begin
							nv_next = in_byte[7:STAT_NV_LSB];
						end
					end
				end
				ST_ID, ST_DONE, ST_SLEEP, ST_WAKE: begin
				end
			endcase
		end else if (selected && !held && sck_fall && talking) begin
			// drive on fall, hold last bit
			so_next = tx_reg[31];
			tx_next = {tx_reg[30:0], tx_reg[0]};
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg      <= ST_OPCODE;
			cnt_reg        <= 5'h0;
			rx_reg         <= 16'h0;
			tx_reg         <= 32'h0;
			so_reg         <= 1'b0;
			addr_reg       <= '0;
			wel_reg        <= 1'b0;
			nv_reg         <= STAT_NV_RESET;
			arm_reg        <= 1'b0;
			wcmd_reg       <= 1'b0;
			wake_reg       <= 16'h0;
			push_valid_reg <= 1'b0;
			push_data_reg  <= '0;
		end else begin
			state_reg      <= state_next;
			cnt_reg        <= cnt_next;
			rx_reg         <= rx_next;
			tx_reg         <= tx_next;
			so_reg         <= so_next;
			addr_reg       <= addr_next;
			wel_reg        <= wel_next;
			nv_reg         <= nv_next;
			arm_reg        <= arm_next;
			wcmd_reg       <= wcmd_next;
			wake_reg       <= wake_next;
			push_valid_reg <= push_valid_next;
			push_data_reg  <= push_data_next;
		end
	end

	assign so_o    = so_reg;
	assign so_oe_o = selected & ~held & talking;

	// checks
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	logic op_done;
	assign op_done = selected & ~held & sck_rise & ~cs_rise
		& (state_reg == ST_OPCODE) & (cnt_reg == 5'h7);

	property p_desel_quiet;
		filt_reg.cs_n |-> !so_oe_o;
	endproperty
	a_desel_quiet: assert property (p_desel_quiet)
		else $error("output enabled while deselected");

	property p_pause_quiet;
		held |-> !so_oe_o ##1 (!so_oe_o || filt_reg.hold_n);
	endproperty
	a_pause_quiet: assert property (p_pause_quiet)
		else $error("output enabled while paused");

	property p_sleep_quiet;
		(state_reg == ST_SLEEP) |-> !so_oe_o && $stable(nv_reg);
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet)
		else $error("activity while asleep");

	property p_latch_set;
		op_done && (in_byte == OP_LATCH_SET) |=> wel_reg;
	endproperty
	a_latch_set: assert property (p_latch_set)
		else $error("latch not set by enable opcode");

	property p_latch_clr;
		(op_done && (in_byte == OP_LATCH_CLR))
			or (cs_rise && !held && wcmd_reg
			&& state_reg != ST_SLEEP && state_reg != ST_WAKE)
			|=> !wel_reg;
	endproperty
	a_latch_clr: assert property (p_latch_clr)
		else $error("latch not cleared");

	property p_write_needs_latch;
		$rose(push_valid_reg) |-> $past(wel_reg);
	endproperty
	a_write_needs_latch: assert property (p_write_needs_latch)
		else $error("write queued with latch clear");

	property p_early_desel;
		cs_rise && (state_reg == ST_OPCODE) |=> $stable(wel_reg)
			&& (state_reg == ST_OPCODE) && (cnt_reg == 5'h0);
	endproperty
	a_early_desel: assert property (p_early_desel)
		else $error("partial opcode had an effect");

	property p_read_step;
		sck_rise && selected && !held && !cs_rise
			&& (state_reg == ST_RDATA) && (cnt_reg == 5'h7)
			|=> addr_reg == $past(addr_reg) + 15'h1;
	endproperty
	a_read_step: assert property (p_read_step)
		else $error("read address did not step");

	property p_sleep_entry;
		cs_rise && arm_reg && !held |=> (state_reg == ST_SLEEP);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry)
		else $error("sleep not entered");

	property p_wake_done;
		(state_reg == ST_WAKE) && (wake_reg == WAKE_LAST)
			|=> (state_reg == ST_OPCODE) && !wel_reg;
	endproperty
	a_wake_done: assert property (p_wake_done)
		else $error("wake did not restore idle");

	c_status_read: cover property (op_done && in_byte == OP_STATUS_RD);
	c_mem_write: cover property (buf_pop);
	c_ident_read: cover property (state_reg == ST_ID && so_oe_o);
	c_sleep: cover property (state_reg == ST_SLEEP ##1 state_reg == ST_WAKE);

endmodule

`default_nettype wire

// ### snm_pkg.sv
/*
 * constants, types and helpers for the serial nonvolatile byte memory.
 * assumes one 100 MHz system clock; all pins sampled by that clock.
 */
`default_nettype none

package snm_pkg;

	localparam int ADDR_W    = 15;
	localparam int MEM_WORDS = 32768;
	localparam int BUF_DEPTH = 2;

	// opcodes
	localparam logic [7:0] OP_LATCH_SET  = 8'h06;
	localparam logic [7:0] OP_LATCH_CLR  = 8'h04;
	localparam logic [7:0] OP_STATUS_RD  = 8'h05;
	localparam logic [7:0] OP_STATUS_WR  = 8'h01;
	localparam logic [7:0] OP_MEM_RD     = 8'h03;
	localparam logic [7:0] OP_MEM_WR     = 8'h02;
	localparam logic [7:0] OP_IDENT_RD   = 8'h9f;
	localparam logic [7:0] OP_SLEEP      = 8'hb9;

	// status layout: [7] protect enable, [6:4] spare, [3:2] region, [1] latch
	localparam int         STAT_NV_LSB   = 2;
	localparam int         STAT_PEN_IDX  = 5;
	localparam int         STAT_RHI_IDX  = 1;
	localparam int         STAT_RLO_IDX  = 0;
	localparam logic [5:0] STAT_NV_RESET = 6'h00;

	localparam logic [ADDR_W-1:0] REGION_QTR_BASE  = 15'h6000;
	localparam logic [ADDR_W-1:0] REGION_HALF_BASE = 15'h4000;

	localparam int CLK_PERIOD_NS         = 10;
	localparam int WAKE_RECOVERY_TIME_US = 400;
	localparam int WAKE_CYCLES = WAKE_RECOVERY_TIME_US * 1000 / CLK_PERIOD_NS;

	// identifier word, value arbitrary
	localparam logic [31:0] ID_WORD = 32'h5a_7f_c3_21;

	typedef enum logic [3:0] {
		ST_OPCODE, ST_ADDR, ST_RDATA, ST_WDATA, ST_SRD,
		ST_SWR, ST_ID, ST_DONE, ST_SLEEP, ST_WAKE
	} snm_state_type;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic hold_n;
		logic wp_n;
	} snm_pins_type;

	localparam snm_pins_type PINS_IDLE = 5'h13;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} snm_wr_req_type;

	function automatic logic region_locked(input logic [ADDR_W-1:0] a,
		input logic [1:0] bp);
		unique case (bp)
			2'h0: region_locked = 1'b0;
			2'h1: region_locked = (a >= REGION_QTR_BASE);
			2'h2: region_locked = (a >= REGION_HALF_BASE);
			2'h3: region_locked = 1'b1;
		endcase
	endfunction

	function automatic logic [7:0] status_byte(input logic [5:0] nv,
		input logic write_enable_latch);
		status_byte = {nv, write_enable_latch, 1'b0};
	endfunction

endpackage

`default_nettype wire

// ### snm_host_model.sv
/*
 * spi host model driving the serial memory pins, mode 0 or mode 3.
 * assumes clk_sys_i at 100 MHz; serial clock half period is 4 clk.
 */
`default_nettype none

module snm_host_model (
	input  wire logic clk_sys_i,
	input  wire logic so_i,
	input  wire logic so_oe_i,
	output var  logic cs_n_o,
	output var  logic sck_o,
	output var  logic si_o,
	output var  logic hold_n_o,
	output var  logic wp_n_o
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		cs_n_o   = 1'b1;
		sck_o    = 1'b0;
		si_o     = 1'b0;
		hold_n_o = 1'b1;
		wp_n_o   = 1'b1;
	end

	// pins move just after a clock edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic sel(input bit m3);
		sck_o = m3;
		tick(4);
		cs_n_o = 1'b0;
		tick(4);
	endtask

	task automatic desel(input bit m3);
		if (!m3) begin
			sck_o = 1'b0;
		end
		tick(4);
		cs_n_o = 1'b1;
		tick(8);
	endtask

	// shift out msb first, sample so at end of high phase
	task automatic xbits(input int n, input logic [31:0] d,
		output logic [31:0] q);
		q = 32'h0;
		for (int i = n - 1; i >= 0; i--) begin
			sck_o = 1'b0;
			si_o  = d[i];
			tick(4);
			sck_o = 1'b1;
			tick(4);
			// released line reads as inverse
			q = {q[30:0], so_oe_i ? so_i : ~so_i};
		end
	endtask

	// pause with sck high, clocks during pause are noise
	task automatic pause(input int n, output logic oe);
		hold_n_o = 1'b0;
		tick(6);
		oe = so_oe_i;
		repeat (n) begin
			sck_o = 1'b0;
			si_o  = ~si_o;
			tick(4);
			sck_o = 1'b1;
			tick(4);
		end
		hold_n_o = 1'b1;
		tick(6);
	endtask

	task automatic pause_drop();
		hold_n_o = 1'b0;
		tick(6);
		cs_n_o = 1'b1;
		tick(6);
		hold_n_o = 1'b1;
		tick(8);
	endtask

	task automatic set_guard(input logic v);
		wp_n_o = v;
		tick(4);
	endtask

endmodule

`default_nettype wire

// ### spi_nonvolatile_byte_memory_tb_top.sv
/*
 * self-checking bench for the spi serial memory.
 * assumes the host model drives all pins; wake count shortened to 200.
 */
`default_nettype none

module spi_nonvolatile_byte_memory_tb_top
	import snm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic      clk_sys_i = 1'b0;
	logic      rst_n_i   = 1'b0;
	wire logic cs_n;
	wire logic sck;
	wire logic si;
	wire logic hold_n;
	wire logic wp_n;
	wire logic so;
	wire logic so_oe;
	int   error_cnt   = 0;
	int   comparisons = 0;

	always #5 clk_sys_i = ~clk_sys_i;

	snm_spi_mem #(.WAKE_CYCLES_P(200)) u_dut (
		.clk_sys_i       (clk_sys_i),
		.rst_n_i         (rst_n_i),
		.cs_n_i          (cs_n),
		.sck_i           (sck),
		.si_i            (si),
		.hold_n_i        (hold_n),
		.write_guard_n_i (wp_n),
		.so_o            (so),
		.so_oe_o         (so_oe)
	);

	snm_host_model u_host (
		.clk_sys_i (clk_sys_i),
		.so_i      (so),
		.so_oe_i   (so_oe),
		.cs_n_o    (cs_n),
		.sck_o     (sck),
		.si_o      (si),
		.hold_n_o  (hold_n),
		.wp_n_o    (wp_n)
	);

	task automatic close_out();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic frame(input bit m3, input logic [7:0] op, input int n,
		input logic [31:0] d, output logic [31:0] q);
		u_host.sel(m3);
		u_host.xbits(8, {24'h0, op}, q);
		if (n > 0) begin
			u_host.xbits(n, d, q);
		end
		u_host.desel(m3);
	endtask

	task automatic stat_is(input logic [7:0] exp);
		logic [31:0] q;
		frame(1'b0, OP_STATUS_RD, 8, 32'h0, q);
		check(q[7:0], exp);
	endtask

	task automatic latch_set_cmd();
		logic [31:0] q;
		frame(1'b0, OP_LATCH_SET, 0, 32'h0, q);
	endtask

	task automatic wr_stat(input logic [7:0] v);
		logic [31:0] q;
		latch_set_cmd();
		frame(1'b0, OP_STATUS_WR, 8, {24'h0, v}, q);
	endtask

	task automatic t_latch();
		logic [31:0] q;
		check(so_oe, 1'b0);
		stat_is(8'h00);
		latch_set_cmd();
		stat_is(8'h02);
		frame(1'b0, OP_LATCH_CLR, 0, 32'h0, q);
		stat_is(8'h00);
	endtask

	task automatic t_status();
		logic [31:0] q;
		wr_stat(8'hff);
		frame(1'b1, OP_STATUS_RD, 16, 32'h0, q);
		check(q[15:0], 16'hfcfc);
		frame(1'b0, OP_STATUS_WR, 8, 32'h0, q);
		stat_is(8'hfc);
		u_host.set_guard(1'b0);
		wr_stat(8'h00);
		stat_is(8'hfc);
		u_host.set_guard(1'b1);
		wr_stat(8'hb3);
		stat_is(8'hb0);
		wr_stat(8'h00);
	endtask

	task automatic t_mem();
		logic [31:0] q;
		latch_set_cmd();
		frame(1'b0, OP_MEM_WR, 32, 32'hffff_abcd, q);
		stat_is(8'h00);
		frame(1'b1, OP_MEM_RD, 32, 32'h7fff_0000, q);
		check(q[15:0], 16'habcd);
		frame(1'b0, OP_MEM_WR, 24, 32'h007f_ff11, q);
		frame(1'b0, OP_MEM_RD, 24, 32'h0, q);
		check(q[7:0], 8'hcd);
		frame(1'b0, OP_MEM_RD, 24, 32'h7fff_00, q);
		check(q[7:0], 8'hab);
	endtask

	task automatic t_protect();
		logic [31:0] q;
		latch_set_cmd();
		frame(1'b0, OP_MEM_WR, 32, 32'h5fff_0055, q);
		wr_stat(8'h04);
		stat_is(8'h04);
		latch_set_cmd();
		frame(1'b0, OP_MEM_WR, 32, 32'h5fff_a1a2, q);
		frame(1'b0, OP_MEM_RD, 32, 32'h5fff_0000, q);
		check(q[15:0], 16'ha155);
		wr_stat(8'h00);
	endtask

	task automatic t_ident();
		logic [31:0] q;
		u_host.sel(1'b0);
		u_host.xbits(8, {24'h0, OP_IDENT_RD}, q);
		u_host.xbits(32, 32'h0, q);
		check(q, ID_WORD);
		u_host.xbits(8, 32'h0, q);
		check(q[7:0], {8{ID_WORD[0]}});
		u_host.desel(1'b0);
	endtask

	task automatic t_abort();
		logic [31:0] q;
		latch_set_cmd();
		u_host.sel(1'b0);
		u_host.xbits(7, {24'h0, OP_LATCH_CLR >> 1}, q);
		u_host.desel(1'b0);
		stat_is(8'h02);
	endtask

	task automatic t_hold();
		logic [31:0] q;
		logic [31:0] q2;
		logic        oe;
		latch_set_cmd();
		u_host.sel(1'b0);
		u_host.xbits(8, {24'h0, OP_STATUS_RD}, q);
		u_host.xbits(4, 32'h0, q);
		u_host.pause(3, oe);
		check(oe, 1'b0);
		u_host.xbits(4, 32'h0, q2);
		u_host.desel(1'b0);
		check({q[3:0], q2[3:0]}, 8'h02);
		u_host.sel(1'b0);
		u_host.xbits(8, {24'h0, OP_STATUS_WR}, q);
		u_host.pause_drop();
		stat_is(8'h02);
	endtask

	task automatic t_sleep();
		logic [31:0] q;
		latch_set_cmd();
		u_host.sel(1'b0);
		u_host.xbits(9, {23'h0, OP_SLEEP, 1'b0}, q);
		u_host.desel(1'b0);
		stat_is(8'h02);
		frame(1'b0, OP_SLEEP, 0, 32'h0, q);
		u_host.sel(1'b0);
		u_host.xbits(16, {16'h0, OP_STATUS_RD, 8'h0}, q);
		check(so_oe, 1'b0);
		u_host.tick(200);
		u_host.desel(1'b0);
		stat_is(8'h00);
	endtask

	initial begin
		repeat (12) @(posedge clk_sys_i);
		#1;
		rst_n_i = 1'b1;
		u_host.tick(8);
		t_latch();
		t_status();
		t_mem();
		t_protect();
		t_ident();
		t_abort();
		t_hold();
		t_sleep();
		close_out();
	end

	// watchdog well beyond the expected run
	initial begin
		#500000;
		error_cnt++;
		close_out();
	end

endmodule

`default_nettype wire
